// >>> shared/comparator_control_irq_pkg.sv
// Package for the comparator control and interrupt block.
// Assumes byte-wide registers placed in the low bits of 32-bit APB words.
package comparator_control_irq_pkg;
  // Printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] IDX_CONTROL_B = 8'h05;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'h06;
  localparam logic [7:0] IDX_DIGITAL_DISABLE = 8'h60;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam int ADDR_W = 10;
  // Control/status field positions
  localparam int POWER_OFF_BIT = 7;
  localparam int BANDGAP_BIT = 6;
  localparam int SYNC_OUT_BIT = 5;
  localparam int EVENT_FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int CAPTURE_BIT = 2;
  // Control B field positions
  localparam int HYST_SEL_BIT = 7;
  localparam int HYST_LEVEL_BIT = 6;
  localparam int MUX_EN_BIT = 2;
  localparam logic [7:0] CONTROL_B_WMASK = 8'hEF;
  // Digital disable field positions
  localparam int NEG_PIN_OFF_BIT = 2;
  localparam int POS_PIN_OFF_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Event modes
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  // Local interrupt status bits
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_RISE_BIT = 1;
  localparam int IRQ_FALL_BIT = 2;
  localparam logic [2:0] IRQ_NONE = 3'h0;
  // Bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_e;
endpackage

// >>> sim/comparator_control_irq_tb.sv
// Self-checking bench for the comparator control and interrupt block.
// Assumes the package word indices and the comparator model beside it.
`timescale 1ns/10ps
module comparator_control_irq_tb;
  import comparator_control_irq_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, comparator_raw, err, pos_above = 1'b0, bg_above = 1'b0;
  logic global_irq_enable = 1'b0, vector_ack = 1'b0, converter_enable = 1'b0;
  logic positive_pin_in = 1'b0, negative_pin_in = 1'b0, comparator_power_off;
  logic bandgap_positive_select, negative_from_mux, hysteresis_enable, hysteresis_level;
  logic capture_input, comparator_irq, positive_pin_digital_off, negative_pin_digital_off;
  logic positive_pin_read, negative_pin_read, irq;
  logic timer_capture_irq_enable = 1'b1, capture_irq;
  logic [31:0] rv;
  int fail_count = 0, num_checks = 0, cycles = 0, m, e, seed = 32'h0A3D33CA;
  comparator_control_irq comparator_control_irq_i (.clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .comparator_raw,
    .global_irq_enable, .vector_ack, .converter_enable, .positive_pin_in,
    .negative_pin_in, .comparator_power_off, .bandgap_positive_select,
    .negative_from_mux, .hysteresis_enable, .hysteresis_level, .capture_input,
    .comparator_irq, .positive_pin_digital_off, .negative_pin_digital_off,
    .positive_pin_read, .negative_pin_read, .irq);
  comparator_model comparator_model_i (.power_off(comparator_power_off),
    .bandgap_sel(bandgap_positive_select), .pos_above(pos_above),
    .bg_above(bg_above), .capture_in(capture_input),
    .timer_capture_irq_enable(timer_capture_irq_enable), .comparator_raw(comparator_raw),
    .capture_irq(capture_irq));
  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs are read at an edge, before that edge's own updates land
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  function automatic logic ev(int md, logic rise);
    return md == 0 || (md == 3 && rise) || (md == 2 && !rise);
  endfunction
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(0, IDX_CONTROL_STATUS, 0);
    chk(rd, 0);
    apb(0, 8'h07, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset test done");
    for (m = 0; m < 4; m++) begin
      converter_enable <= m[0];
      apb(1, IDX_CONTROL_B, (m << 6) | 32'h14);
      apb(0, IDX_CONTROL_B, 0);
      chk(rd, (m << 6) | 32'h04);
      settle;
      chk({hysteresis_enable, hysteresis_level}, {m[1], m[1] & m[0]});
      chk(negative_from_mux, !m[0]);
      rv = $random(seed);
      positive_pin_in <= rv[0];
      negative_pin_in <= rv[1];
      apb(1, IDX_DIGITAL_DISABLE, m << 1);
      settle;
      chk({positive_pin_read, negative_pin_read}, {rv[0] & !m[0], rv[1] & !m[1]});
      chk({positive_pin_digital_off, negative_pin_digital_off}, {m[0], m[1]});
    end
    $display("control b test done");
    pos_above <= 1'b1;
    apb(1, IDX_CONTROL_STATUS, 32'hC4);
    settle;
    chk({comparator_power_off, bandgap_positive_select, capture_input}, 3'h6);
    bg_above <= 1'b1;
    pos_above <= 1'b0;
    apb(1, IDX_CONTROL_STATUS, 32'h44);
    settle;
    chk(capture_input, 1);
    chk(capture_irq, 1);
    timer_capture_irq_enable <= 1'b0;
    @(posedge clk);
    chk(capture_irq, 0);
    timer_capture_irq_enable <= 1'b1;
    apb(1, IDX_CONTROL_STATUS, 32'h00);
    settle;
    chk(capture_input, 0);
    chk(capture_irq, 0);
    $display("routing test done");
    for (m = 0; m < 4; m++) begin
      apb(1, IDX_CONTROL_STATUS, m | 32'h10);
      for (e = 0; e < 2; e++) begin
        pos_above <= (e == 0);
        settle;
        apb(0, IDX_CONTROL_STATUS, 0);
        chk(rd[5:4], {e == 0, ev(m, e == 0)});
        apb(1, IDX_CONTROL_STATUS, m | 32'h10);
      end
    end
    $display("event mode test done");
    apb(1, IDX_CONTROL_STATUS, 32'h18);
    pos_above <= 1'b1;
    settle;
    chk(comparator_irq, 0);
    global_irq_enable <= 1'b1;
    settle;
    chk(comparator_irq, 1);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    settle;
    chk(comparator_irq, 0);
    pos_above <= 1'b0;
    apb(1, IDX_CONTROL_STATUS, 32'h08);
    settle;
    chk(comparator_irq, 1);
    apb(1, IDX_CONTROL_STATUS, 32'h18);
    settle;
    chk(comparator_irq, 0);
    $display("flag test done");
    apb(0, IDX_IRQ_STATUS, 0);
    apb(1, IDX_IRQ_MASK, 1);
    pos_above <= 1'b1;
    settle;
    chk(irq, 1);
    apb(0, IDX_IRQ_STATUS, 0);
    chk(rd, 3);
    settle;
    chk(irq, 0);
    $display("interrupt test done");
    test_done();
  end
endmodule

// >>> sim/comparator_model.sv
// Behavioural analog comparator core facing the control block.
// Assumes the bench commands which input stands higher as plain levels.
// Also stands in for the timer capture front end and its interrupt mask.
`timescale 1ns/10ps
module comparator_model (
  input wire logic power_off,
  input wire logic bandgap_sel,
  input wire logic pos_above,
  input wire logic bg_above,
  input wire logic capture_in,
  input wire logic timer_capture_irq_enable,
  output logic comparator_raw,
  output logic capture_irq
);
  // A routed capture only interrupts when the timer's own mask allows it
  assign capture_irq = capture_in && timer_capture_irq_enable;
  // An unpowered core reads low, so a power change can look like an edge
  assign comparator_raw = power_off ? 1'b0 : (bandgap_sel ? bg_above : pos_above);
endmodule

// >>> verilog/comparator_control_irq.sv
// Control, event and interrupt logic around an analog comparator core.
// Assumes the port pins are synchronous inputs at 125 MHz; the comparator output goes through a two-stage synchronizer.
// How it works
// R01: Power-off bit switches comparator power off
// R02: Software disables irq before changing power-off
// R03: Bandgap bit replaces positive input pin
// R04: Output synchronized, read-only, one-two cycles late
// R05: Selected edge sets event flag
// R06: Irq needs flag, enable and global enable
// R07: Flag cleared by vector or writing one
// R08: Mode: toggle, reserved, falling, rising
// R09: Software disables irq before changing mode
// R10: Capture bit routes output to timer capture
// R11: Software sets timer capture irq enable
// R12: Hysteresis enable; level picks 20/50 mV
// R13: Mux enable with converter off picks negative
// R14: Control B bit four reads zero
// R15: Software writes zero to touch bits
// R16: Digital-disable bits gate pin buffers to zero
// R17: Edge from current versus previous sample
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module comparator_control_irq
  import comparator_control_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_raw,
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  input wire logic converter_enable,
  input wire logic positive_pin_in,
  input wire logic negative_pin_in,
  output logic comparator_power_off,
  output logic bandgap_positive_select,
  output logic negative_from_mux,
  output logic hysteresis_enable,
  output logic hysteresis_level,
  output logic capture_input,
  output logic comparator_irq,
  output logic positive_pin_digital_off,
  output logic negative_pin_digital_off,
  output logic positive_pin_read,
  output logic negative_pin_read,
  output logic irq
);

  logic [7:0] ctrl_status_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] didr_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_mask_r;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  bus_state_e bus_state_r;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic rise;
  logic fall;
  logic event_hit;
  logic [7:0] rd_byte;
  logic mapped;
  logic [1:0] mode;

  // Word index from byte address
  assign idx = paddr[ADDR_W-1:2];
  // Writes land at the edge that completes the transfer, where pready is high
  assign wr_en = psel && penable && pwrite && pready && (bus_state_r == BUS_DONE) && pstrb[0];
  assign rd_en = psel && penable && !pwrite && (bus_state_r == BUS_IDLE);
  assign mode = ctrl_status_r[1:0];

  // Decode whether an index names a register
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_CONTROL_B) || (i == IDX_CONTROL_STATUS) ||
                (i == IDX_DIGITAL_DISABLE) || (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
  endfunction
  assign mapped = is_mapped(idx);

  // Two-stage synchronizer; only the second stage is looked at
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= comparator_raw; // R04
      sync2_r <= sync1_r; // R04
      prev_r <= sync2_r; // R17
    end
  end

  // Edge detection, once per clock, on the synchronized output
  assign rise = sync2_r && !prev_r; // R17
  assign fall = !sync2_r && prev_r; // R17
  always_comb begin
    case (mode) // R08
      MODE_TOGGLE: event_hit = rise || fall;
      MODE_FALL: event_hit = fall;
      MODE_RISE: event_hit = rise;
      default: event_hit = 1'b0; // Reserved code raises nothing
    endcase
  end

  // Control/status register; the event flag set beats any clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_status_r <= RESET_BYTE;
    end else begin
      if (wr_en && idx == IDX_CONTROL_STATUS) begin
        ctrl_status_r[7:6] <= pwdata[7:6];
        ctrl_status_r[3:0] <= pwdata[3:0];
      end
      if (event_hit) begin
        ctrl_status_r[EVENT_FLAG_BIT] <= 1'b1; // R05
      end else if (vector_ack) begin
        ctrl_status_r[EVENT_FLAG_BIT] <= 1'b0; // R07
      end else if (wr_en && idx == IDX_CONTROL_STATUS && pwdata[EVENT_FLAG_BIT]) begin
        ctrl_status_r[EVENT_FLAG_BIT] <= 1'b0; // R07
      end
    end
  end

  // Control B and digital-disable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_b_r <= RESET_BYTE;
      didr_r <= RESET_BYTE;
    end else begin
      if (wr_en && idx == IDX_CONTROL_B) begin
        ctrl_b_r <= pwdata[7:0] & CONTROL_B_WMASK; // R14
      end
      if (wr_en && idx == IDX_DIGITAL_DISABLE) begin
        didr_r <= pwdata[7:0];
      end
    end
  end

  // Local interrupt status, cleared by reading it; a new event wins over the read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_r <= IRQ_NONE;
      irq_mask_r <= IRQ_NONE;
    end else begin
      if (wr_en && idx == IDX_IRQ_MASK) begin
        irq_mask_r <= pwdata[2:0];
      end
      irq_status_r <= ((rd_en && idx == IDX_IRQ_STATUS) ? IRQ_NONE : irq_status_r) |
                      {fall, rise, event_hit};
    end
  end

  // Read mux
  always_comb begin
    case (idx)
      IDX_CONTROL_STATUS: rd_byte = {ctrl_status_r[7:6], sync2_r, ctrl_status_r[4:0]}; // R04
      IDX_CONTROL_B: rd_byte = ctrl_b_r; // R14
      IDX_DIGITAL_DISABLE: rd_byte = didr_r;
      IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status_r};
      IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_r};
      default: rd_byte = RESET_BYTE;
    endcase
  end

  // APB slave: one wait state, ready registered; unmapped gives pslverr
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_state_r <= BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (psel && penable) begin
            bus_state_r <= BUS_DONE;
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
          end
        end
        BUS_DONE: begin
          bus_state_r <= BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // Analog controls and routed outputs, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comparator_power_off <= 1'b0;
      bandgap_positive_select <= 1'b0;
      negative_from_mux <= 1'b0;
      hysteresis_enable <= 1'b0;
      hysteresis_level <= 1'b0;
      capture_input <= 1'b0;
      comparator_irq <= 1'b0;
      positive_pin_digital_off <= 1'b0;
      negative_pin_digital_off <= 1'b0;
      positive_pin_read <= 1'b0;
      negative_pin_read <= 1'b0;
      irq <= 1'b0;
    end else begin
      comparator_power_off <= ctrl_status_r[POWER_OFF_BIT]; // R01
      bandgap_positive_select <= ctrl_status_r[BANDGAP_BIT]; // R03
      negative_from_mux <= ctrl_b_r[MUX_EN_BIT] && !converter_enable; // R13
      hysteresis_enable <= ctrl_b_r[HYST_SEL_BIT]; // R12
      // Level is meaningless while hysteresis is off, so hold it low then
      hysteresis_level <= ctrl_b_r[HYST_SEL_BIT] && ctrl_b_r[HYST_LEVEL_BIT]; // R12
      capture_input <= ctrl_status_r[CAPTURE_BIT] && sync2_r; // R10
      comparator_irq <= ctrl_status_r[EVENT_FLAG_BIT] && ctrl_status_r[IRQ_EN_BIT] &&
                        global_irq_enable; // R06
      positive_pin_digital_off <= didr_r[POS_PIN_OFF_BIT]; // R16
      negative_pin_digital_off <= didr_r[NEG_PIN_OFF_BIT]; // R16
      positive_pin_read <= positive_pin_in && !didr_r[POS_PIN_OFF_BIT]; // R16
      negative_pin_read <= negative_pin_in && !didr_r[NEG_PIN_OFF_BIT]; // R16
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // Checks
  AST_SYNC_LATENCY: assert property (@(posedge clk) disable iff (!rstn)
    comparator_raw |-> ##2 sync2_r) else $error("sync output late"); // R04
  AST_RISE_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    (mode == MODE_RISE && rise) |=> ctrl_status_r[EVENT_FLAG_BIT])
    else $error("rise did not set flag"); // R05
  AST_RESERVED_MODE: assert property (@(posedge clk) disable iff (!rstn)
    (mode == 2'h1) |-> !event_hit) else $error("reserved mode raised event"); // R08
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rstn)
    comparator_irq |-> $past(ctrl_status_r[IRQ_EN_BIT] && global_irq_enable))
    else $error("irq without enables"); // R06
  AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    (vector_ack && !event_hit) |=> !ctrl_status_r[EVENT_FLAG_BIT])
    else $error("ack did not clear flag"); // R07
  AST_POWER: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_status_r[POWER_OFF_BIT] |=> comparator_power_off) else $error("power not off"); // R01
  AST_BIT4_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_b_r[4]) else $error("control b bit four set"); // R14
  AST_MUX: assert property (@(posedge clk) disable iff (!rstn)
    converter_enable |=> !negative_from_mux) else $error("mux with converter on"); // R13
  AST_PIN_OFF: assert property (@(posedge clk) disable iff (!rstn)
    didr_r[POS_PIN_OFF_BIT] |=> !positive_pin_read) else $error("pin read not zero"); // R16
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_status_r[CAPTURE_BIT] |=> !capture_input) else $error("capture leak"); // R10
  AST_BANDGAP: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_status_r[BANDGAP_BIT] |=> bandgap_positive_select) else $error("bandgap off"); // R03
  AST_HYST: assert property (@(posedge clk) disable iff (!rstn)
    hysteresis_level |-> hysteresis_enable) else $error("level without hysteresis"); // R12
  // Further forms of the earlier checks, so an output stuck high or stuck low is caught too; last, a ready pulse check and a local irq check
  AST_FALL_FLAG: assert property (@(posedge clk) disable iff (!rstn) // R05
    (mode == MODE_FALL && fall) |=> ctrl_status_r[EVENT_FLAG_BIT])
    else $error("fall did not set flag");
  AST_TOGGLE_FLAG: assert property (@(posedge clk) disable iff (!rstn) // R08
    (mode == MODE_TOGGLE && (rise || fall)) |=> ctrl_status_r[EVENT_FLAG_BIT])
    else $error("toggle did not set flag");
  AST_WRITE_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // R07
    (wr_en && idx == IDX_CONTROL_STATUS && pwdata[EVENT_FLAG_BIT] && !event_hit) |=>
    !ctrl_status_r[EVENT_FLAG_BIT]) else $error("write one did not clear flag");
  AST_IRQ_ON: assert property (@(posedge clk) disable iff (!rstn) // R06
    (ctrl_status_r[EVENT_FLAG_BIT] && ctrl_status_r[IRQ_EN_BIT] && global_irq_enable) |=>
    comparator_irq) else $error("irq missing");
  AST_SYNC_LOW: assert property (@(posedge clk) disable iff (!rstn)
    !comparator_raw |-> ##2 !sync2_r) else $error("sync output stuck high"); // R04
  AST_CAPTURE_ON: assert property (@(posedge clk) disable iff (!rstn) // R10
    (ctrl_status_r[CAPTURE_BIT] && sync2_r) |=> capture_input)
    else $error("capture not routed");
  AST_NEG_PIN_OFF: assert property (@(posedge clk) disable iff (!rstn) // R16
    didr_r[NEG_PIN_OFF_BIT] |=> !negative_pin_read)
    else $error("negative pin read not zero");
  AST_POWER_ON: assert property (@(posedge clk) disable iff (!rstn) // R01
    !ctrl_status_r[POWER_OFF_BIT] |=> !comparator_power_off)
    else $error("power off stuck");
  AST_MUX_ON: assert property (@(posedge clk) disable iff (!rstn) // R13
    (ctrl_b_r[MUX_EN_BIT] && !converter_enable) |=> negative_from_mux)
    else $error("mux not selected");
  AST_READY_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready) else $error("ready longer than one cycle");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
    (|(irq_status_r & irq_mask_r)) |=> irq)
    else $error("unmasked status without irq");
  COV_TOGGLE: cover property (@(posedge clk) mode == MODE_TOGGLE && event_hit);
  COV_FALL: cover property (@(posedge clk) mode == MODE_FALL && fall);
  COV_IRQ: cover property (@(posedge clk) comparator_irq);
  COV_LOCAL_IRQ: cover property (@(posedge clk) irq);
  COV_READ_CLEAR: cover property (@(posedge clk) rd_en && idx == IDX_IRQ_STATUS && |irq_status_r);

endmodule
